// file: bmc_top.sv
// buzzer and melody controller: two note slots, tone, length, gap, power
// window timer, byte register port, level interrupt
// assumes all inputs synchronous to clock; slow_osc_clock is a level
//
// Behaviour
// - two note slots A and B, each with divisor, length and gap
// - tone base is clock divided by 32, or by 64 when base bit set
// - tone frequency is tone base over twelve-bit divisor plus one
// - tone sounds length times unit, then gap times unit follows
// - unit select 00..11 gives 1, 2, 4 or 8 ms
// - notes play once in sequence or alternate by restarting them
// - any note start restarts the power window timer
// - power window expiry sets a flag held until software clears it
// - power window output high from note start until expiry
// - writing one to a go bit starts a note; cleared on completion
// - both go bits set plays A first, then B
// - completion with end enable sets end flag; write zero clears
// - per-note playing bit set while that note is in progress
`timescale 1ns/100ps
`default_nettype none
module bmc_top
	import bmc_pkg::*;
#(
	parameter int unsigned SLOW_PER_UNIT = BMC_SLOW_PER_UNIT
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [15:0] bus_addr,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        bus_we,
	input  wire logic        bus_re,
	output logic      [7:0]  bus_rdata,
	input  wire logic        slow_osc_clock,
	output logic             buzzer_out,
	output logic             power_on_width,
	output logic             irq
);

	// last slow tick of a unit: 1, 2, 4 or 8 ms
	function automatic logic [8:0] unit_last(input logic [1:0] sel);
		logic [8:0] base;
		base = 9'(SLOW_PER_UNIT);
		unit_last = (base << sel) - 9'h001;
	endfunction

	// high half of one tone period, rounded up so divisor 0 still sounds
	function automatic logic wave_high(input logic [11:0] cnt,
		input logic [11:0] div);
		logic [12:0] half;
		half = ({1'b0, div} + 13'h0002) >> 1;
		wave_high = {1'b0, cnt} < half;
	endfunction

	// note slot storage
	logic [11:0] div_q [2];
	logic [7:0]  len_q [2];
	logic [7:0]  gap_q [2];

	// control and status
	logic        en_q;
	logic        pol_q;
	logic [1:0]  ien_q;
	logic [1:0]  flg_q;
	logic [1:0]  flg_d;
	logic [1:0]  go_q;
	logic [1:0]  go_d;
	logic [1:0]  sel_q;
	logic        base_q;
	logic        pie_q;
	logic        pflg_q;
	logic        pflg_d;
	logic [7:0]  pow_len_q;
	logic [BMC_IRQ_W-1:0] stat_q;
	logic [BMC_IRQ_W-1:0] stat_d;
	logic [BMC_IRQ_W-1:0] mask_q;
	logic [7:0]  rdata_q;

	// sequencer
	bmc_state_e  state_q;
	logic        cur_q;
	logic [7:0]  cnt_q;
	logic        done;
	logic [1:0]  done_vec;

	// timing
	logic [5:0]  pre_q;
	logic        base_tick;
	logic [11:0] tone_cnt_q;
	logic        slow_q;
	logic        slow_rise;
	logic [8:0]  unit_q;
	logic        unit_tick;
	logic        pow_on_q;
	logic [7:0]  pow_cnt_q;
	logic        pow_expire;
	logic        buzz_q;

	// address decode
	wire         note_hit = bus_addr[15:3] == BMC_A_DIV_LO[15:3];
	wire         slot     = bus_addr[BMC_SLOT_BIT];
	wire [1:0]   field    = bus_addr[1:0];
	wire         wr_note  = bus_we && note_hit;
	wire         wr_cfg   = bus_we && bus_addr == BMC_CFG;
	wire         wr_pow   = bus_we && bus_addr == BMC_POW;
	wire         wr_tu    = bus_we && bus_addr == BMC_TU;
	wire         wr_mask  = bus_we && bus_addr == BMC_IRQ_MASK;
	wire         rd_stat  = bus_re && bus_addr == BMC_IRQ_STAT;
	wire [1:0]   wr_go    = wr_cfg ?
		bus_wdata[BMC_CFG_GO_B:BMC_CFG_GO_A] : 2'h0;
	wire         start    = |wr_go;
	wire         playing  = state_q != BMC_IDLE;
	wire [1:0]   busy     = {playing && cur_q, playing && !cur_q};
	wire [11:0]  cur_div  = div_q[cur_q];
	wire [7:0]   cfg_rd   = {en_q, pol_q, ien_q, flg_q, busy};
	wire [7:0]   tu_rd    = {sel_q, 1'b0, base_q, 2'h0, pie_q, pflg_q};

	// note slot writes
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			div_q <= '{default: 12'h000};
			len_q <= '{default: BMC_RST_BYTE};
			gap_q <= '{default: BMC_RST_BYTE};
		end else if (wr_note) begin
			unique case (field)
				BMC_F_LO:  div_q[slot][7:0] <= bus_wdata;
				BMC_F_HI:  div_q[slot][11:8] <= bus_wdata[3:0];
				BMC_F_LEN: len_q[slot] <= bus_wdata;
				BMC_F_GAP: gap_q[slot] <= bus_wdata;
			endcase
		end
	end

	// go bits: a new start wins over completion
	assign go_d = (go_q & ~done_vec) | wr_go;

	// end flags: hardware set wins over software write of zero
	assign flg_d = (wr_cfg ?
		flg_q & bus_wdata[BMC_CFG_FLG_B:BMC_CFG_FLG_A] : flg_q)
		| (done_vec & ien_q);

	// power flag: held until software writes zero
	assign pflg_d = (wr_tu ? pflg_q & bus_wdata[BMC_TU_PFLG] : pflg_q)
		| pow_expire;

	// sticky status, cleared by reading it; events win
	assign stat_d = (rd_stat ? '0 : stat_q)
		| {pow_expire, done_vec};

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			en_q  <= 1'b0;
			pol_q <= 1'b0;
			ien_q <= 2'h0;
		end else if (wr_cfg) begin
			en_q  <= bus_wdata[BMC_CFG_EN];
			pol_q <= bus_wdata[BMC_CFG_POL];
			ien_q <= bus_wdata[BMC_CFG_IEN_B:BMC_CFG_IEN_A];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sel_q  <= 2'h0;
			base_q <= 1'b0;
			pie_q  <= 1'b0;
		end else if (wr_tu) begin
			sel_q  <= bus_wdata[BMC_TU_SEL_HI:BMC_TU_SEL_LO];
			base_q <= bus_wdata[BMC_TU_BASE];
			pie_q  <= bus_wdata[BMC_TU_PIE];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pow_len_q <= BMC_RST_BYTE;
			mask_q    <= '0;
		end else begin
			if (wr_pow)
				pow_len_q <= bus_wdata;
			if (wr_mask)
				mask_q <= bus_wdata[BMC_IRQ_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			go_q   <= 2'h0;
			flg_q  <= 2'h0;
			pflg_q <= 1'b0;
			stat_q <= '0;
		end else begin
			go_q   <= go_d;
			flg_q  <= flg_d;
			pflg_q <= pflg_d;
			stat_q <= stat_d;
		end
	end

	// read data, valid only in the cycle after the strobe
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (note_hit) begin
			unique case (field)
				BMC_F_LO:  rd_mux = div_q[slot][7:0];
				BMC_F_HI:  rd_mux = {4'h0, div_q[slot][11:8]};
				BMC_F_LEN: rd_mux = len_q[slot];
				BMC_F_GAP: rd_mux = gap_q[slot];
			endcase
		end else if (bus_addr == BMC_CFG) begin
			rd_mux = cfg_rd;
		end else if (bus_addr == BMC_POW) begin
			rd_mux = pow_len_q;
		end else if (bus_addr == BMC_TU) begin
			rd_mux = tu_rd;
		end else if (bus_addr == BMC_IRQ_STAT) begin
			rd_mux = {5'h00, stat_q};
		end else if (bus_addr == BMC_IRQ_MASK) begin
			rd_mux = {5'h00, mask_q};
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			rdata_q <= 8'h00;
		else
			rdata_q <= bus_re ? rd_mux : 8'h00;
	end

	// tone base prescaler
	assign base_tick = pre_q == (base_q ? BMC_PRE_SLOW_LAST
		: BMC_PRE_FAST_LAST);

	always_ff @(posedge clock) begin
		if (!rst_b || base_tick)
			pre_q <= 6'h00;
		else
			pre_q <= pre_q + 6'h01;
	end

	// unit timer from slow oscillator edges
	assign slow_rise = slow_osc_clock && !slow_q;
	assign unit_tick = slow_rise && unit_q >= unit_last(sel_q);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			slow_q <= 1'b0;
			unit_q <= 9'h000;
		end else begin
			slow_q <= slow_osc_clock;
			if (unit_tick)
				unit_q <= 9'h000;
			else if (slow_rise)
				unit_q <= unit_q + 9'h001;
		end
	end

	// sequencer: A has priority, then B; each note tone then gap
	assign done     = en_q && state_q == BMC_GAP
		&& cnt_q == gap_q[cur_q];
	assign done_vec = {done && cur_q, done && !cur_q};

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_q <= BMC_IDLE;
			cur_q   <= 1'b0;
			cnt_q   <= 8'h00;
		end else if (!en_q) begin
			state_q <= BMC_IDLE;
			cnt_q   <= 8'h00;
		end else begin
			unique case (state_q)
				BMC_IDLE: begin
					cnt_q <= 8'h00;
					if (|go_q) begin
						state_q <= BMC_TONE;
						cur_q   <= !go_q[0];
					end
				end
				BMC_TONE: begin
					if (cnt_q == len_q[cur_q]) begin
						state_q <= BMC_GAP;
						cnt_q   <= 8'h00;
					end else if (unit_tick) begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				BMC_GAP: begin
					if (done) begin
						state_q <= BMC_IDLE;
						cnt_q   <= 8'h00;
					end else if (unit_tick) begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
			endcase
		end
	end

	// tone period counter, div + 1 base ticks per period
	always_ff @(posedge clock) begin
		if (!rst_b || state_q != BMC_TONE)
			tone_cnt_q <= 12'h000;
		else if (base_tick) begin
			if (tone_cnt_q >= cur_div)
				tone_cnt_q <= 12'h000;
			else
				tone_cnt_q <= tone_cnt_q + 12'h001;
		end
	end

	// buzzer pin: polarity applied to tone, inactive level in gap
	always_ff @(posedge clock) begin
		if (!rst_b)
			buzz_q <= 1'b0;
		else
			buzz_q <= (state_q == BMC_TONE &&
				wave_high(tone_cnt_q, cur_div)) ^ pol_q;
	end

	// power window timer
	assign pow_expire = pow_on_q && !start && pow_cnt_q == pow_len_q;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pow_on_q  <= 1'b0;
			pow_cnt_q <= 8'h00;
		end else if (start) begin
			pow_on_q  <= 1'b1;
			pow_cnt_q <= 8'h00;
		end else if (pow_expire) begin
			pow_on_q <= 1'b0;
		end else if (pow_on_q && unit_tick) begin
			pow_cnt_q <= pow_cnt_q + 8'h01;
		end
	end

	assign bus_rdata      = rdata_q;
	assign buzzer_out     = buzz_q;
	assign power_on_width = pow_on_q;
	assign irq = (pflg_q && pie_q)
		|| (|flg_q) || (|(stat_q & mask_q));

endmodule
`default_nettype wire

// file: bmc_pkg.sv
// constants and types of the buzzer and melody controller
// assumes a byte-wide register port and a synchronous slow oscillator level
`default_nettype none
package bmc_pkg;
	// register byte addresses
	localparam logic [15:0] BMC_A_DIV_LO = 16'ha040;
	localparam logic [15:0] BMC_A_DIV_HI = 16'ha041;
	localparam logic [15:0] BMC_A_LEN    = 16'ha042;
	localparam logic [15:0] BMC_A_GAP    = 16'ha043;
	localparam logic [15:0] BMC_B_DIV_LO = 16'ha044;
	localparam logic [15:0] BMC_B_DIV_HI = 16'ha045;
	localparam logic [15:0] BMC_B_LEN    = 16'ha046;
	localparam logic [15:0] BMC_B_GAP    = 16'ha047;
	localparam logic [15:0] BMC_CFG      = 16'ha048;
	localparam logic [15:0] BMC_POW      = 16'ha049;
	localparam logic [15:0] BMC_TU       = 16'ha04a;
	localparam logic [15:0] BMC_IRQ_STAT = 16'ha04b;
	localparam logic [15:0] BMC_IRQ_MASK = 16'ha04c;
	// note slot fields, low address bits
	localparam logic [1:0] BMC_F_LO  = 2'h0;
	localparam logic [1:0] BMC_F_HI  = 2'h1;
	localparam logic [1:0] BMC_F_LEN = 2'h2;
	localparam logic [1:0] BMC_F_GAP = 2'h3;
	localparam int unsigned BMC_SLOT_BIT = 2;
	// configuration register bits
	localparam int unsigned BMC_CFG_EN    = 7;
	localparam int unsigned BMC_CFG_POL   = 6;
	localparam int unsigned BMC_CFG_IEN_B = 5;
	localparam int unsigned BMC_CFG_IEN_A = 4;
	localparam int unsigned BMC_CFG_FLG_B = 3;
	localparam int unsigned BMC_CFG_FLG_A = 2;
	localparam int unsigned BMC_CFG_GO_B  = 1;
	localparam int unsigned BMC_CFG_GO_A  = 0;
	// time unit register bits
	localparam int unsigned BMC_TU_SEL_HI = 7;
	localparam int unsigned BMC_TU_SEL_LO = 6;
	localparam int unsigned BMC_TU_BASE   = 4;
	localparam int unsigned BMC_TU_PIE    = 1;
	localparam int unsigned BMC_TU_PFLG   = 0;
	// sticky status bits
	localparam int unsigned BMC_IRQ_A = 0;
	localparam int unsigned BMC_IRQ_B = 1;
	localparam int unsigned BMC_IRQ_P = 2;
	localparam int unsigned BMC_IRQ_W = 3;
	// timing
	localparam int unsigned BMC_SLOW_OSC_HZ = 32000;
	localparam int unsigned BMC_UNIT_MS     = 1;
	localparam int unsigned BMC_MS_PER_S    = 1000;
	localparam int unsigned BMC_SLOW_PER_UNIT =
		BMC_SLOW_OSC_HZ * BMC_UNIT_MS / BMC_MS_PER_S;
	localparam logic [5:0] BMC_PRE_FAST_LAST = 6'h1f;
	localparam logic [5:0] BMC_PRE_SLOW_LAST = 6'h3f;
	localparam logic [7:0] BMC_RST_BYTE = 8'h00;
	typedef enum logic [1:0] {
		BMC_IDLE,
		BMC_TONE,
		BMC_GAP
	} bmc_state_e;
endpackage
`default_nettype wire

// file: bmc_top_asserts.sv
// port checker for bmc_top
// assumes bmc_pkg compiled first; bound into every bmc_top
`timescale 1ns/100ps
`default_nettype none
module bmc_top_asserts
	import bmc_pkg::*;
#(
	parameter int unsigned SLOW_PER_UNIT = BMC_SLOW_PER_UNIT
) (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0]  bus_wdata,
	input wire logic        bus_we,
	input wire logic        bus_re,
	input wire logic [7:0]  bus_rdata,
	input wire logic        slow_osc_clock,
	input wire logic        buzzer_out,
	input wire logic        power_on_width,
	input wire logic        irq
);
	logic       pie_q;
	logic [7:0] len_q;
	logic       cfg_go;
	assign cfg_go = bus_we && bus_addr == BMC_CFG && |bus_wdata[1:0];
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pie_q <= 1'b0;
			len_q <= BMC_RST_BYTE;
		end else if (bus_we && bus_addr == BMC_TU) begin
			pie_q <= bus_wdata[BMC_TU_PIE];
		end else if (bus_we && bus_addr == BMC_A_LEN) begin
			len_q <= bus_wdata;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_rdata_idle: assert property (!$past(bus_re) |-> bus_rdata == 8'h00)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property ($past(bus_re && bus_addr > BMC_IRQ_MASK)
		|-> bus_rdata == 8'h00) else $error("unmapped read not zero");
	a_div_nibble: assert property ($past(bus_re && bus_addr == BMC_A_DIV_HI)
		|-> bus_rdata[7:4] == 4'h0) else $error("divisor high bits set");
	a_tu_spare: assert property ($past(bus_re && bus_addr == BMC_TU)
		|-> bus_rdata[5] == 1'b0 && bus_rdata[3:2] == 2'h0)
		else $error("unit register spare bits set");
	a_len_echo: assert property ($past(bus_re && bus_addr == BMC_A_LEN)
		|-> bus_rdata == len_q) else $error("length readback wrong");
	a_go_powers: assert property (cfg_go |=> power_on_width)
		else $error("start did not open power window");
	a_pow_cause: assert property ($rose(power_on_width) |-> $past(cfg_go))
		else $error("power window opened without start");
	a_pow_irq: assert property ($fell(power_on_width) && pie_q |-> irq)
		else $error("power expiry without interrupt");
	a_irq_sticky: assert property (irq && !bus_we && !bus_re |=> irq)
		else $error("interrupt dropped without access");
endmodule
bind bmc_top bmc_top_asserts #(.SLOW_PER_UNIT(SLOW_PER_UNIT)) u_bmc_top_asserts (
	.clock, .rst_b, .bus_addr, .bus_wdata, .bus_we, .bus_re, .bus_rdata,
	.slow_osc_clock, .buzzer_out, .power_on_width, .irq);
`default_nettype wire

// file: bmc_buzzer_model.sv
// buzzer element behind its power switch: counts tone edges heard
// assumes buzzer_out and power_on_width come from bmc_top on clock
`timescale 1ns/100ps
`default_nettype none
module bmc_buzzer_model (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic buzzer_out,
	input  wire logic power_on_width,
	output var  int   heard
);
	logic last_q;
	always_ff @(posedge clock) begin
		last_q <= buzzer_out;
		if (!rst_b)
			heard <= 0;
		else if (power_on_width && buzzer_out && !last_q)
			heard <= heard + 1;
	end
endmodule
`default_nettype wire

// file: bmc_top_test.sv
// self-checking bench for bmc_top over its byte register port
// assumes bmc_pkg, checker and buzzer model compiled first
`timescale 1ns/100ps
`default_nettype none
module bmc_top_test;
	import bmc_pkg::*;
	logic            clock, rst_b, bus_we, bus_re, slow_osc_clock;
	logic     [15:0] bus_addr;
	logic     [7:0]  bus_wdata;
	logic     [1:0]  sdiv;
	wire logic [7:0] bus_rdata;
	wire logic       buzzer_out, power_on_width, irq;
	int              n_fail, checks_done, n, u, heard;
	bmc_top #(.SLOW_PER_UNIT(2)) u_bmc_top (.clock, .rst_b, .bus_addr,
		.bus_wdata, .bus_we, .bus_re, .bus_rdata, .slow_osc_clock,
		.buzzer_out, .power_on_width, .irq);
	bmc_buzzer_model u_bmc_buzzer_model (.clock, .rst_b, .buzzer_out,
		.power_on_width, .heard);
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		sdiv <= sdiv + 2'h1;
		if (sdiv == 2'h3)
			slow_osc_clock <= ~slow_osc_clock;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] s, e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic rng(input string nm, input int v, lo, hi);
		chk(nm, {7'h0, v >= lo && v <= hi}, 8'h01);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		bus_addr <= a;
		bus_wdata <= d;
		bus_we <= 1'b1;
		@(posedge clock);
		bus_we <= 1'b0;
		#1;
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] e, string nm);
		@(posedge clock);
		bus_addr <= a;
		bus_re <= 1'b1;
		@(posedge clock);
		bus_re <= 1'b0;
		#1 chk(nm, bus_rdata, e);
	endtask
	function automatic logic sg(input int s);
		return s == 0 ? buzzer_out : s == 1 ? power_on_width : irq;
	endfunction
	task automatic wt(input int s, input logic l, output int c);
		c = 0;
		#1;
		while (sg(s) !== l) begin
			@(posedge clock);
			#1 c++;
			if (c > 40000) begin
				n_fail++;
				print_verdict();
			end
		end
	endtask
	initial begin
		rst_b = 1'b0;
		bus_we = 1'b0;
		bus_re = 1'b0;
		bus_addr = 16'h0000;
		bus_wdata = 8'h00;
		slow_osc_clock = 1'b0;
		sdiv = 2'h0;
		n_fail = 0;
		checks_done = 0;
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		for (int a = 'ha040; a <= 'ha04d; a++)
			rc(16'(a), 8'h00, "reset_value");
		for (int a = 'ha040; a <= 'ha049; a++) begin
			if (a != 'ha048) begin
				wr(16'(a), 8'ha5);
				rc(16'(a), (a == 'ha041 || a == 'ha045) ? 8'h05 : 8'ha5,
					"readback");
			end
		end
		wr(BMC_POW, 8'h00);
		wr(BMC_CFG, 8'h40);
		repeat (4) @(posedge clock);
		chk("idle_pol", {7'h0, buzzer_out}, 8'h01);
		chk("no_start", {7'h0, power_on_width}, 8'h00);
		wr(BMC_CFG, 8'h00);
		for (int i = 0; i < 2; i++) begin
			wr(BMC_A_DIV_LO, i ? 8'h03 : 8'h02);
			wr(BMC_A_DIV_HI, i ? 8'h00 : 8'h01);
			wr(BMC_A_LEN, 8'hff);
			wr(BMC_TU, i ? 8'hd0 : 8'hc0);
			wr(BMC_CFG, 8'h81);
			wt(0, 1, n);
			wt(0, 0, n);
			wt(0, 1, n);
			wt(0, 0, n);
			wt(0, 1, u);
			rng("tone_period", n + u, i ? 256 : 8288, i ? 256 : 8288);
			wr(BMC_CFG, 8'h00);
		end
		wr(BMC_A_DIV_LO, 8'h00);
		wr(BMC_A_DIV_HI, 8'h00);
		wr(BMC_A_LEN, 8'h03);
		wr(BMC_A_GAP, 8'h02);
		for (int s = 0; s < 4; s++) begin
			wr(BMC_TU, 8'(s << 6));
			wr(BMC_CFG, 8'h91);
			wt(0, 1, n);
			wt(0, 0, n);
			rng("tone_len", n, 2 * (16 << s) - 1, 3 * (16 << s) + 2);
			wt(2, 1, n);
			rng("gap_len", n, (16 << s) - 1, 2 * (16 << s) + 2);
			rc(BMC_CFG, 8'h94, "done_cfg");
			wr(BMC_CFG, 8'h80);
			chk("flag_clear", {7'h0, irq}, 8'h00);
		end
		wr(BMC_TU, 8'h00);
		wr(BMC_B_LEN, 8'h03);
		wr(BMC_B_GAP, 8'h00);
		wr(BMC_CFG, 8'hb3);
		rc(BMC_CFG, 8'hb1, "a_first");
		wt(2, 1, n);
		rc(BMC_CFG, 8'hb6, "b_next");
		wt(0, 0, n);
		repeat (3) @(posedge clock);
		rc(BMC_CFG, 8'hbc, "both_done");
		wr(BMC_CFG, 8'h80);
		rc(BMC_IRQ_STAT, 8'h07, "status");
		wr(BMC_POW, 8'h02);
		wr(BMC_A_LEN, 8'h0a);
		wr(BMC_TU, 8'h02);
		wr(BMC_CFG, 8'h81);
		wt(1, 1, n);
		wt(1, 0, n);
		rng("pow_len", n, 15, 34);
		chk("pow_irq", {7'h0, irq}, 8'h01);
		rc(BMC_TU, 8'h03, "pow_flag");
		wr(BMC_IRQ_MASK, 8'h04);
		wr(BMC_TU, 8'h00);
		chk("mask_irq", {7'h0, irq}, 8'h01);
		rc(BMC_IRQ_STAT, 8'h04, "status_p");
		chk("read_clr", {7'h0, irq}, 8'h00);
		chk("heard", {7'h0, heard != 0}, 8'h01);
		wr(BMC_CFG, 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
